// ### verification/spi_master_model.sv
// Four-wire serial master model driving the alarm slave
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic i_clk,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_sdi,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
    end

    // Half of a 200 ns serial period, moved on falling edges of the system clock
    task automatic half();
        repeat (4) @(negedge i_clk);
    endtask

    task automatic frame(input logic [7:0] dir, input logic [7:0] addr,
                         input logic [7:0] data, output logic [7:0] rd);
        logic [23:0] word;
        word = {dir, addr, data};
        rd = 8'h00;
        o_cs_n = 1'b0;
        half();
        for (int i = 23; i >= 0; i--) begin
            o_sclk = 1'b0;
            // Released during read data: toggle so a stale level never passes
            o_sdi = (i < 8 && !dir[0]) ? ~o_sdi : word[i];
            half();
            o_sclk = 1'b1;
            half();
            // Sampled late in the high phase to allow for the slave's sync latency
            if (i < 8) begin
                rd = {rd[6:0], i_sdo_oe ? i_sdo : 1'bx};
            end
        end
        o_sclk = 1'b0;
        half();
        o_cs_n = 1'b1;
        repeat (4) half();
    endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the serial alarm slave
`timescale 1ns/1ps
`include "spi_alarm_defines.svh"
module testbench;
    logic                   clk = 1'b0;
    logic                   rstn = 1'b0;
    logic                   proto = 1'b0;
    logic                   ce = 1'b1;
    logic                   cs_n, sclk, sdi, sdo, sdo_oe, irq_n;
    logic [3:0]             pll_loss = 4'h0;
    logic [3:0]             in_loss = 4'h0;
    logic [7:0]             irq_sel = 8'hff;
    spi_alarm_pkg::byte_t   v;
    int                     miscompares = 0;
    int                     n_checks = 0;

    always #12.5 clk = ~clk;

    spi_master_model master (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi),
                             .i_sdo(sdo), .i_sdo_oe(sdo_oe));
    spi_slave_alarm_registers dut (.I_CLK(clk), .I_RSTN(rstn), .I_CE(ce),
        .I_HOST_PROTOCOL_SELECT(proto), .I_CHIP_SELECT_PIN_N(cs_n), .I_SCLK(sclk),
        .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_PLL_LOCK_LOSS(pll_loss),
        .I_INPUT_LOSS(in_loss), .I_IRQ_SELECT(irq_sel), .O_ALARM_IRQ_N(irq_n));

    task automatic check(input string name, input spi_alarm_pkg::byte_t seen,
                         input spi_alarm_pkg::byte_t exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Direction bytes differ in the ignored bits to show only the eighth counts
    task automatic wr(input spi_alarm_pkg::byte_t a, input spi_alarm_pkg::byte_t d);
        master.frame(8'h55, a, d, v);
    endtask

    task automatic rd(input spi_alarm_pkg::byte_t a);
        master.frame(8'hfe, a, 8'h00, v);
    endtask

    task automatic settle();
        repeat (30) @(negedge clk);
    endtask

    task automatic complete_run();
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic test_reset_values();
        check("irq after reset", {7'h00, irq_n}, 8'h00);
        rd(`ADDR_PAGE_SELECT);
        check("page reset", v, `PAGE_RESET);
        rd(`ADDR_PLL_LOSS_STICKY);
        check("pll sticky reset", v, 8'h0f);
        rd(`ADDR_PLL_LOSS_ENABLE);
        check("pll enable reset", v, 8'h0f);
        check("oe after read", {7'h00, sdo_oe}, 8'h00);
    endtask

    task automatic test_page_and_clear();
        wr(`ADDR_PAGE_SELECT, `PAGE_INPUT);
        rd(`ADDR_PAGE_SELECT);
        check("page select", v, `PAGE_INPUT);
        irq_sel = 8'hf0;
        wr(`ADDR_INPUT_LOSS_STICKY, 8'hff);
        rd(`ADDR_INPUT_LOSS_STICKY);
        check("input sticky cleared", v, 8'h00);
        check("irq with only input selected", {7'h00, irq_n}, 8'h01);
    endtask

    task automatic test_live_and_enable();
        in_loss = 4'h5;
        settle();
        rd(`ADDR_INPUT_LOSS_LIVE);
        check("input live", v, 8'h05);
        rd(`ADDR_INPUT_LOSS_STICKY);
        check("input sticky set", v, 8'h05);
        check("irq low on sticky", {7'h00, irq_n}, 8'h00);
        wr(`ADDR_INPUT_LOSS_ENABLE, 8'hfa);
        wr(`ADDR_INPUT_LOSS_STICKY, 8'hff);
        in_loss = 4'h0;
        settle();
        in_loss = 4'hf;
        settle();
        rd(`ADDR_INPUT_LOSS_ENABLE);
        check("input enable upper dropped", v, 8'h0a);
        rd(`ADDR_INPUT_LOSS_STICKY);
        check("masked stickies stay clear", v, 8'h0a);
        rd(8'h10);
        check("unmapped read", v, 8'h00);
    endtask

    task automatic test_pll_page();
        wr(`ADDR_PAGE_SELECT, `PAGE_PLL);
        pll_loss = 4'h3;
        settle();
        rd(`ADDR_PLL_LOSS_LIVE);
        check("pll live", v, 8'h03);
        rd(`ADDR_INPUT_LOSS_LIVE);
        check("input live not on page 0", v, 8'h00);
        wr(`ADDR_PLL_LOSS_ENABLE, 8'h01);
        wr(`ADDR_PLL_LOSS_STICKY, 8'hff);
        irq_sel = 8'h0f;
        rd(`ADDR_PLL_LOSS_STICKY);
        check("pll sticky cleared", v, 8'h00);
        check("irq high once pll stickies clear", {7'h00, irq_n}, 8'h01);
        pll_loss = 4'h0;
        settle();
        pll_loss = 4'hf;
        settle();
        rd(`ADDR_PLL_LOSS_STICKY);
        check("pll sticky only enabled bit", v, 8'h01);
        check("irq low on pll sticky", {7'h00, irq_n}, 8'h00);
        rd(`ADDR_PLL_LOSS_ENABLE);
        check("pll enable written", v, 8'h01);
    endtask

    // A whole frame sent while the clock enable is low must leave no trace
    task automatic test_clock_enable();
        ce = 1'b0;
        wr(`ADDR_PAGE_SELECT, `PAGE_INPUT);
        ce = 1'b1;
        settle();
        rd(`ADDR_PAGE_SELECT);
        check("page kept while frozen", v, `PAGE_PLL);
    endtask

    task automatic test_mode_select();
        proto = 1'b1;
        settle();
        wr(`ADDR_PAGE_SELECT, `PAGE_INPUT);
        proto = 1'b0;
        settle();
        rd(`ADDR_PAGE_SELECT);
        check("page kept in other mode", v, `PAGE_PLL);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        test_reset_values();
        test_page_and_clear();
        test_live_and_enable();
        test_pll_page();
        test_mode_select();
        test_clock_enable();
        complete_run();
    end

    // Twenty-six frames of about 5.4 microseconds each fit well inside this span
    initial begin
        #600000;
        miscompares++;
        complete_run();
    end
endmodule

// ### verilog/spi_alarm_defines.svh
// Register offsets, reset values and timing counts for the serial alarm slave
`ifndef SPI_ALARM_DEFINES_SVH
`define SPI_ALARM_DEFINES_SVH

`define ADDR_PAGE_SELECT        8'hff
`define ADDR_INPUT_LOSS_LIVE    8'h02
`define ADDR_INPUT_LOSS_STICKY  8'h03
`define ADDR_INPUT_LOSS_ENABLE  8'h04
`define ADDR_PLL_LOSS_LIVE      8'h06
`define ADDR_PLL_LOSS_STICKY    8'h07
`define ADDR_PLL_LOSS_ENABLE    8'h08

`define PAGE_PLL                8'h00
`define PAGE_INPUT              8'h01

`define PAGE_RESET              8'h00
`define STICKY_RESET            4'hf
`define ENABLE_RESET            4'hf

`define DIR_BIT_COUNT           5'd8
`define ADDR_BIT_COUNT          5'd16
`define FRAME_BIT_COUNT         5'd24

`define SYS_CLK_HZ              40000000
`define RC_CLK_HZ               4000000
`define RC_TICK_CYCLES          ((`SYS_CLK_HZ) / (`RC_CLK_HZ))

`endif

// ### verilog/spi_alarm_pkg.sv
// Types shared by the serial alarm slave
package spi_alarm_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] alarm_t;
    typedef logic [4:0] bit_count_t;
endpackage

// ### verilog/spi_slave_alarm_registers.sv
// Four-wire serial slave with paged lock-loss and clock-loss alarm registers
`timescale 1ns/1ps
`include "spi_alarm_defines.svh"

module spi_slave_alarm_registers (
    input  wire logic       I_CLK,
    input  wire logic       I_RSTN,
    input  wire logic       I_CE,
    input  wire logic       I_HOST_PROTOCOL_SELECT,
    input  wire logic       I_CHIP_SELECT_PIN_N,
    input  wire logic       I_SCLK,
    input  wire logic       I_SDI,
    output logic            O_SDO,
    output logic            O_SDO_OE,
    input  wire logic [3:0] I_PLL_LOCK_LOSS,
    input  wire logic [3:0] I_INPUT_LOSS,
    input  wire logic [7:0] I_IRQ_SELECT,
    output logic            O_ALARM_IRQ_N
);

    // Two-flop synchronisers for the serial pins, mode select and both alarm inputs
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] sdi_sync;
    logic [1:0] mode_sync;
    logic [3:0] pll_sync1;
    logic [3:0] input_sync1;

    logic                     sclk_prev;
    spi_alarm_pkg::alarm_t    pll_live;
    spi_alarm_pkg::alarm_t    input_live;
    spi_alarm_pkg::alarm_t    pll_prev;
    spi_alarm_pkg::alarm_t    input_prev;
    spi_alarm_pkg::alarm_t    pll_sticky;
    spi_alarm_pkg::alarm_t    input_sticky;
    spi_alarm_pkg::alarm_t    pll_enable;
    spi_alarm_pkg::alarm_t    input_enable;
    spi_alarm_pkg::alarm_t    pll_clear;
    spi_alarm_pkg::alarm_t    input_clear;
    spi_alarm_pkg::byte_t     page;
    spi_alarm_pkg::byte_t     rx_shift;
    spi_alarm_pkg::byte_t     addr;
    spi_alarm_pkg::byte_t     wdata;
    spi_alarm_pkg::byte_t     tx_shift;
    spi_alarm_pkg::bit_count_t bit_count;
    logic                     dir_write;
    logic                     wr_stb;
    logic [3:0]               rc_div;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sclk_sync   <= 2'h0;
            cs_sync     <= 2'h3;
            sdi_sync    <= 2'h0;
            mode_sync   <= 2'h3;
            pll_sync1   <= 4'h0;
            input_sync1 <= 4'h0;
            pll_live    <= 4'h0;
            input_live  <= 4'h0;
            sclk_prev   <= 1'b0;
        end else if (I_CE) begin
            sclk_sync   <= {sclk_sync[0], I_SCLK};
            cs_sync     <= {cs_sync[0], I_CHIP_SELECT_PIN_N};
            sdi_sync    <= {sdi_sync[0], I_SDI};
            mode_sync   <= {mode_sync[0], I_HOST_PROTOCOL_SELECT};
            pll_sync1   <= I_PLL_LOCK_LOSS;
            input_sync1 <= I_INPUT_LOSS;
            pll_live    <= pll_sync1;
            input_live  <= input_sync1;
            sclk_prev   <= sclk_sync[1];
        end
    end

    wire frame_active = !cs_sync[1] && !mode_sync[1];
    wire sclk_rise    = frame_active && sclk_sync[1] && !sclk_prev;
    wire sclk_fall    = frame_active && !sclk_sync[1] && sclk_prev;
    wire bit_in       = sdi_sync[1];
    // Bits past the 24th are ignored so a long frame cannot touch a second register
    wire take_bit     = sclk_rise && (bit_count < `FRAME_BIT_COUNT);
    wire read_load    = sclk_fall && !dir_write && (bit_count == `ADDR_BIT_COUNT);
    wire read_shift   = sclk_fall && !dir_write && (bit_count > `ADDR_BIT_COUNT)
                        && (bit_count < `FRAME_BIT_COUNT);
    wire next_wr_stb  = sclk_fall && dir_write && (bit_count == `FRAME_BIT_COUNT);
    wire [7:0] next_rx = {rx_shift[6:0], bit_in};

    function automatic spi_alarm_pkg::byte_t read_mux(
        input spi_alarm_pkg::byte_t pg,
        input spi_alarm_pkg::byte_t ad,
        input spi_alarm_pkg::alarm_t p_live,
        input spi_alarm_pkg::alarm_t p_sticky,
        input spi_alarm_pkg::alarm_t p_enable,
        input spi_alarm_pkg::alarm_t i_live,
        input spi_alarm_pkg::alarm_t i_sticky,
        input spi_alarm_pkg::alarm_t i_enable);
        spi_alarm_pkg::byte_t value;
        value = 8'h00;
        if (ad == `ADDR_PAGE_SELECT) begin
            value = pg;
        end else if (pg == `PAGE_PLL) begin
            if (ad == `ADDR_PLL_LOSS_LIVE) value = {4'h0, p_live};
            if (ad == `ADDR_PLL_LOSS_STICKY) value = {4'h0, p_sticky};
            if (ad == `ADDR_PLL_LOSS_ENABLE) value = {4'h0, p_enable};
        end else if (pg == `PAGE_INPUT) begin
            if (ad == `ADDR_INPUT_LOSS_LIVE) value = {4'h0, i_live};
            if (ad == `ADDR_INPUT_LOSS_STICKY) value = {4'h0, i_sticky};
            if (ad == `ADDR_INPUT_LOSS_ENABLE) value = {4'h0, i_enable};
        end
        return value;
    endfunction

    // Combinational mux settles well inside half a serial clock period
    wire [7:0] rd_data = read_mux(page, addr, pll_live, pll_sticky, pll_enable,
                                  input_live, input_sticky, input_enable);

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            bit_count <= 5'd0;
            rx_shift  <= 8'h00;
            dir_write <= 1'b0;
            addr      <= 8'h00;
            wdata     <= 8'h00;
        end else if (I_CE) begin
            if (!frame_active) begin
                bit_count <= 5'd0;
            end else if (take_bit) begin
                bit_count <= bit_count + 5'd1;
                rx_shift  <= next_rx;
                if (bit_count == `DIR_BIT_COUNT - 5'd1) dir_write <= bit_in;
                if (bit_count == `ADDR_BIT_COUNT - 5'd1) addr <= next_rx;
                if (bit_count == `FRAME_BIT_COUNT - 5'd1) wdata <= next_rx;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tx_shift <= 8'h00;
            O_SDO    <= 1'b0;
            O_SDO_OE <= 1'b0;
            wr_stb   <= 1'b0;
        end else if (I_CE) begin
            wr_stb <= next_wr_stb;
            if (!frame_active) begin
                O_SDO_OE <= 1'b0;
            end else if (read_load) begin
                tx_shift <= rd_data;
                O_SDO    <= rd_data[7];
                O_SDO_OE <= 1'b1;
            end else if (read_shift) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                O_SDO    <= tx_shift[6];
            end
        end
    end

    // Write decode, valid in the cycle the commit strobe is high
    wire wr_page      = wr_stb && (addr == `ADDR_PAGE_SELECT);
    wire wr_pll_page  = wr_stb && (page == `PAGE_PLL);
    wire wr_in_page   = wr_stb && (page == `PAGE_INPUT);
    wire wr_pll_stky  = wr_pll_page && (addr == `ADDR_PLL_LOSS_STICKY);
    wire wr_pll_en    = wr_pll_page && (addr == `ADDR_PLL_LOSS_ENABLE);
    wire wr_in_stky   = wr_in_page && (addr == `ADDR_INPUT_LOSS_STICKY);
    wire wr_in_en     = wr_in_page && (addr == `ADDR_INPUT_LOSS_ENABLE);

    // The RC rate is a tick derived from the system clock
    wire rc_tick = (rc_div == 4'h0);
    wire [3:0] pll_rise   = pll_live & ~pll_prev;
    wire [3:0] input_rise = input_live & ~input_prev;
    wire [3:0] pll_set    = pll_rise & pll_enable;
    wire [3:0] input_set  = input_rise & input_enable;
    wire [7:0] irq_sources = {input_sticky, pll_sticky} & I_IRQ_SELECT;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            page <= `PAGE_RESET;
            pll_enable <= `ENABLE_RESET;
            input_enable <= `ENABLE_RESET;
        end else if (I_CE) begin
            if (wr_page) page <= wdata;
            if (wr_pll_en) pll_enable <= wdata[3:0];
            if (wr_in_en) input_enable <= wdata[3:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rc_div       <= 4'h0;
            pll_prev     <= 4'h0;
            input_prev   <= 4'h0;
            pll_sticky   <= `STICKY_RESET;
            input_sticky <= `STICKY_RESET;
            pll_clear    <= 4'h0;
            input_clear  <= 4'h0;
            O_ALARM_IRQ_N <= 1'b1;
        end else if (I_CE) begin
            rc_div <= rc_tick ? 4'(`RC_TICK_CYCLES - 1) : rc_div - 4'h1;
            // Clears wait for the next tick; a new clear in a tick cycle is kept
            pll_clear   <= (rc_tick ? 4'h0 : pll_clear) | (wr_pll_stky ? wdata[3:0] : 4'h0);
            input_clear <= (rc_tick ? 4'h0 : input_clear) | (wr_in_stky ? wdata[3:0] : 4'h0);
            if (rc_tick) begin
                pll_prev     <= pll_live;
                input_prev   <= input_live;
                // Set wins over a clear arriving on the same tick
                pll_sticky   <= (pll_sticky & ~pll_clear) | pll_set;
                input_sticky <= (input_sticky & ~input_clear) | input_set;
            end
            O_ALARM_IRQ_N <= ~|irq_sources;
        end
    end

    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    // Alarm side: sticky, enable, interrupt, tick and page select behaviour
    irq_nor_a: assert property (I_CE |=> O_ALARM_IRQ_N == ~|$past(irq_sources))
        else $error("interrupt output does not match selected sticky bits");
    mask_block_a: assert property (I_CE && rc_tick |=>
            ((pll_sticky & ~$past(pll_sticky) & ~$past(pll_enable)) == 4'h0))
        else $error("sticky bit set while disabled");
    input_mask_a: assert property (I_CE && rc_tick |=>
            ((input_sticky & ~$past(input_sticky) & ~$past(input_enable)) == 4'h0))
        else $error("input sticky bit set while disabled");
    sticky_hold_a: assert property (I_CE && !(rc_tick && |pll_clear) |=>
            ((~pll_sticky & $past(pll_sticky)) == 4'h0))
        else $error("sticky bit dropped without a clear");
    input_hold_a: assert property (I_CE && !(rc_tick && |input_clear) |=>
            ((~input_sticky & $past(input_sticky)) == 4'h0))
        else $error("input sticky bit dropped without a clear");
    pll_clear_a: assert property (I_CE && rc_tick |=>
            ((pll_sticky & $past(pll_clear) & ~$past(pll_set)) == 4'h0))
        else $error("pll sticky bit not cleared");
    input_clear_a: assert property (I_CE && rc_tick |=>
            ((input_sticky & $past(input_clear) & ~$past(input_set)) == 4'h0))
        else $error("input sticky bit not cleared");
    rise_set_a: assert property (I_CE && rc_tick |=>
            ((pll_sticky & $past(pll_set)) == $past(pll_set)))
        else $error("enabled pll status rise did not set sticky bit");
    input_set_a: assert property (I_CE && rc_tick |=>
            ((input_sticky & $past(input_set)) == $past(input_set)))
        else $error("enabled input status rise did not set sticky bit");
    pll_enable_a: assert property (I_CE && wr_pll_en |=>
            pll_enable == $past(wdata[3:0]))
        else $error("pll enable write lost");
    input_enable_a: assert property (I_CE && wr_in_en |=>
            input_enable == $past(wdata[3:0]))
        else $error("input enable write lost");
    rc_period_a: assert property (I_CE && rc_tick |=>
            rc_div == 4'(`RC_TICK_CYCLES - 1))
        else $error("alarm tick period wrong");
    page_select_a: assert property (I_CE && wr_page |=> page == $past(wdata))
        else $error("page select not updated");

    // Serial side: capture, commit and read-out
    dir_capture_a: assert property (I_CE && take_bit &&
            bit_count == `DIR_BIT_COUNT - 5'd1 |=> dir_write == $past(bit_in))
        else $error("direction bit not captured");
    addr_capture_a: assert property (I_CE && take_bit &&
            bit_count == `ADDR_BIT_COUNT - 5'd1 |=> addr == $past(next_rx))
        else $error("address byte not captured");
    data_capture_a: assert property (I_CE && take_bit &&
            bit_count == `FRAME_BIT_COUNT - 5'd1 |=> wdata == $past(next_rx))
        else $error("write data byte not captured");
    write_commit_a: assert property ($rose(wr_stb) |->
            $past(dir_write) && $past(bit_count) == `FRAME_BIT_COUNT)
        else $error("write committed outside 24th falling edge");
    read_load_a: assert property (I_CE && read_load |=>
            O_SDO == $past(rd_data[7]) && O_SDO_OE)
        else $error("first read bit not driven");
    read_oe_a: assert property (I_CE && read_shift |=> O_SDO_OE)
        else $error("read output released during data bits");
    sdo_shift_a: assert property (I_CE && read_shift |=> O_SDO == $past(tx_shift[6]))
        else $error("read bit order wrong");
    sdo_release_a: assert property (I_CE && !frame_active |=> !O_SDO_OE)
        else $error("read output driven outside a frame");
    bit_reset_a: assert property (I_CE && !frame_active |=> bit_count == 5'd0)
        else $error("bit counter kept across frames");
    mode_gate_a: assert property (mode_sync[1] |-> !sclk_rise && !sclk_fall ##1 !wr_stb)
        else $error("slave active in two-wire mode");
    no_burst_a: assert property (bit_count <= `FRAME_BIT_COUNT)
        else $error("bit counter passed frame length");
    upper_zero_a: assert property (addr != `ADDR_PAGE_SELECT |-> rd_data[7:4] == 4'h0)
        else $error("alarm register upper bits not zero");

endmodule
